// >>> hw/psr_router.sv
// Functional notes
// (RULE1) input selector: six bits, upper two read zero
// (RULE2) one input selector per peripheral input function
// (RULE3) software picks only pins an input supports
// (RULE4) interrupt input selector limited to codes below 0x10; the code stores any six-bit code and feeds zero for 0x10 and up
// (RULE5) input selector defaults on power reset only
// (RULE6) output source: six bits, zero on power reset
// (RULE7) routed peripheral overrides pin direction
// (RULE8) lock flag bit zero, cleared every reset
// (RULE9) lock changes only after two key writes
// (RULE10) one-time option: lock set stays until reset
// (RULE11) source code zero drives port latch bit
// (RULE12) only power reset restores selections
// (RULE13) locked writes to selections are ignored
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
module psr_router (
    // clock and resets
    input wire logic mclk,
    input wire logic rst,
    input wire logic soft_rst,
    // configuration
    input wire logic one_time_lock_option,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pins
    input wire logic [psr_pkg::N_PINS-1:0] pin_in,
    output logic [psr_pkg::N_PINS-1:0] pin_out,
    output logic [psr_pkg::N_PINS-1:0] pin_oe,
    // port logic
    input wire logic [psr_pkg::N_PINS-1:0] port_output_latch_bit,
    input wire logic [psr_pkg::N_PINS-1:0] pin_direction_control,
    // peripherals
    input wire logic [psr_pkg::N_SRC-1:0] periph_out,
    input wire logic [psr_pkg::N_SRC-1:0] periph_oe,
    output logic [psr_pkg::N_INPUTS-1:0] periph_in
);
    logic [psr_pkg::N_INPUTS-1:0][psr_pkg::SEL_W-1:0] in_sel_reg;
    logic [psr_pkg::N_PINS-1:0][psr_pkg::SEL_W-1:0] out_src_reg;
    logic selection_locked_flag;
    logic one_way_done_reg;
    psr_pkg::psr_key_e key_reg;
    psr_pkg::psr_key_e key_next;
    logic [psr_pkg::N_PINS-1:0] pin_meta_reg;
    logic [psr_pkg::N_PINS-1:0] pin_sync_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;

    logic access;
    logic wr_fire;
    logic wr_byte0;
    logic hit_lock;
    logic hit_in;
    logic hit_out;
    logic [5:0] word_idx;
    logic [5:0] in_idx;
    logic [5:0] out_idx;
    logic sel_write_ok;
    logic lock_wr;
    logic lock_change_ok;
    logic lock_next;
    logic [31:0] rdata_next;

    assign access = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_fire = access && wb_we_i;
    assign wr_byte0 = wr_fire && wb_sel_i[0];
    assign word_idx = wb_adr_i[7:2];
    assign in_idx = word_idx - psr_pkg::OFF_IN_BASE[7:2];
    assign out_idx = word_idx - psr_pkg::OFF_OUT_BASE[7:2];
    assign hit_lock = (wb_adr_i == psr_pkg::OFF_LOCK);
    assign hit_in = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i >= psr_pkg::OFF_IN_BASE)
        && (in_idx < 6'(psr_pkg::N_INPUTS));
    assign hit_out = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i >= psr_pkg::OFF_OUT_BASE)
        && (out_idx < 6'(psr_pkg::N_PINS));
    assign sel_write_ok = wr_byte0 && !selection_locked_flag; // RULE13
    assign lock_wr = wr_byte0 && hit_lock;

    // key writes never touch the flag; only the write after the pair does
    always_comb begin
        key_next = key_reg;
        if (lock_wr) begin
            if (wb_dat_i[7:0] == psr_pkg::KEY_FIRST) begin
                key_next = psr_pkg::KEY_GOT_FIRST;
            end else if (key_reg == psr_pkg::KEY_GOT_FIRST && wb_dat_i[7:0] == psr_pkg::KEY_SECOND) begin
                key_next = psr_pkg::KEY_ARMED;
            end else begin
                key_next = psr_pkg::KEY_IDLE;
            end
        end else if (wr_fire) begin
            // any other write between key steps breaks the sequence
            key_next = psr_pkg::KEY_IDLE;
        end
    end

    assign lock_change_ok = lock_wr && (key_reg == psr_pkg::KEY_ARMED)
        && !(one_time_lock_option && one_way_done_reg); // RULE10
    assign lock_next = lock_change_ok ? wb_dat_i[psr_pkg::LOCK_BIT] : selection_locked_flag;

    // unmapped words read zero and take no write
    assign rdata_next = hit_lock ? {31'h0000_0000, selection_locked_flag} // RULE8
        : hit_in ? {26'h000_0000, in_sel_reg[in_idx[1:0]]} // RULE1
        : hit_out ? {26'h000_0000, out_src_reg[out_idx[3:0]]} // RULE6
        : 32'h0000_0000;

    // selections: only the power reset restores their defaults
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < psr_pkg::N_INPUTS; i++) begin
                in_sel_reg[i] <= psr_pkg::IN_RESET[i]; // RULE5
            end
            for (int i = 0; i < psr_pkg::N_PINS; i++) begin
                out_src_reg[i] <= psr_pkg::OUT_RESET; // RULE12
            end
        end else if (sel_write_ok && hit_in) begin
            in_sel_reg[in_idx[1:0]] <= wb_dat_i[psr_pkg::SEL_W-1:0]; // RULE2
        end else if (sel_write_ok && hit_out) begin
            out_src_reg[out_idx[3:0]] <= wb_dat_i[psr_pkg::SEL_W-1:0]; // RULE6
        end
    end

    // lock state: every reset clears it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            selection_locked_flag <= psr_pkg::LOCK_RESET;
            one_way_done_reg <= 1'b0;
            key_reg <= psr_pkg::KEY_IDLE;
        end else if (soft_rst) begin
            selection_locked_flag <= psr_pkg::LOCK_RESET; // RULE8
            one_way_done_reg <= 1'b0;
            key_reg <= psr_pkg::KEY_IDLE;
        end else begin
            selection_locked_flag <= lock_next; // RULE9
            one_way_done_reg <= one_way_done_reg || (lock_change_ok && wb_dat_i[psr_pkg::LOCK_BIT]); // RULE10
            key_reg <= key_next;
        end
    end

    // bus answer: one cycle after the strobe, dropped the cycle after
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= access;
            rdata_reg <= access ? rdata_next : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // pin inputs come from outside the clock domain
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // unsupported selector codes feed a steady zero rather than a random pin
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            periph_in <= '0;
        end else begin
            for (int j = 0; j < psr_pkg::N_INPUTS; j++) begin
                periph_in[j] <= (in_sel_reg[j] < 6'(psr_pkg::N_PINS))
                    ? pin_sync_reg[in_sel_reg[j][psr_pkg::PIN_IDX_W-1:0]] : 1'b0; // RULE2
            end
        end
    end

    for (genvar p = 0; p < psr_pkg::N_PINS; p++) begin : g_pin
        psr_pin_drive u_drive (
            .mclk(mclk),
            .rst(rst),
            .src_code(out_src_reg[p]),
            .latch_bit(port_output_latch_bit[p]),
            .dir_input(pin_direction_control[p]),
            .periph_out(periph_out),
            .periph_oe(periph_oe),
            .pin_out_reg(pin_out[p]),
            .pin_oe_reg(pin_oe[p])
        );
    end

    // checks
    logic [psr_pkg::SRC_IDX_W-1:0] chk_src0;
    assign chk_src0 = out_src_reg[0][psr_pkg::SRC_IDX_W-1:0];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // two idle edges between keys, the spacing the xfer task gives; the bus allows as few as one
    sequence key_pair_s;
        lock_wr && wb_dat_i[7:0] == psr_pkg::KEY_FIRST ##1 (!wr_fire && !soft_rst) [*2] ##1
            lock_wr && wb_dat_i[7:0] == psr_pkg::KEY_SECOND;
    endsequence

    read_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:6] == 26'h000_0000) // RULE1
        else $error("read data upper bits not zero");
    locked_ignore_a: assert property (wr_byte0 && selection_locked_flag && !soft_rst |=>
        out_src_reg == $past(out_src_reg) && in_sel_reg == $past(in_sel_reg)) // RULE13
        else $error("selection changed while locked");
    input_write_a: assert property (wr_byte0 && !selection_locked_flag && hit_lock == 1'b0
        && wb_adr_i == psr_pkg::OFF_IN_BASE |=> in_sel_reg[0] == $past(wb_dat_i[5:0])) // RULE2
        else $error("input selector write lost");
    soft_keep_a: assert property (soft_rst |=> !selection_locked_flag
        && out_src_reg == $past(out_src_reg) && in_sel_reg == $past(in_sel_reg)) // RULE12
        else $error("soft reset disturbed selections or kept lock");
    latch_drive_a: assert property (out_src_reg[0] == psr_pkg::CODE_LATCH |=>
        pin_out[0] == $past(port_output_latch_bit[0]) && pin_oe[0] == !$past(pin_direction_control[0])) // RULE11
        else $error("latch bit not driving pin");
    dir_override_a: assert property (out_src_reg[0] != psr_pkg::CODE_LATCH && out_src_reg[0] < 6'(psr_pkg::N_SRC)
        |=> pin_oe[0] == $past(periph_oe[chk_src0])) // RULE7
        else $error("peripheral direction not applied");
    lock_key_a: assert property (!soft_rst && key_reg != psr_pkg::KEY_ARMED |=>
        selection_locked_flag == $past(selection_locked_flag)) // RULE9
        else $error("lock changed without key pair");
    key_arm_a: assert property (key_pair_s |=> key_reg == psr_pkg::KEY_ARMED) // RULE9
        else $error("key pair did not arm lock");
    one_way_a: assert property (one_time_lock_option && one_way_done_reg && !soft_rst |=>
        selection_locked_flag) // RULE10
        else $error("one-time lock released");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");
endmodule : psr_router

// >>> include/psr_pkg.sv
package psr_pkg;
    localparam int N_PINS = 16;
    localparam int N_INPUTS = 3;
    localparam int N_SRC = 16;
    localparam int SEL_W = 6;
    localparam int PIN_IDX_W = 4;
    localparam int SRC_IDX_W = 4;

    // register byte offsets
    localparam logic [7:0] OFF_LOCK = 8'h00;
    localparam logic [7:0] OFF_IN_BASE = 8'h04;
    localparam logic [7:0] OFF_OUT_BASE = 8'h40;

    // input function order: external interrupt, timer0 clock, serial receive
    localparam logic [SEL_W-1:0] IN_RESET [N_INPUTS] = '{6'h00, 6'h04, 6'h17};
    localparam logic [SEL_W-1:0] OUT_RESET = 6'h00;
    localparam logic [SEL_W-1:0] CODE_LATCH = 6'h00;
    localparam logic LOCK_RESET = 1'b0;
    localparam int LOCK_BIT = 0;

    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_GOT_FIRST = 2'b01,
        KEY_ARMED = 2'b10
    } psr_key_e;
endpackage : psr_pkg

// >>> hw/psr_pin_drive.sv
`timescale 1ns/100ps
module psr_pin_drive (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // selection
    input wire logic [psr_pkg::SEL_W-1:0] src_code,
    input wire logic latch_bit,
    input wire logic dir_input,
    // peripheral outputs
    input wire logic [psr_pkg::N_SRC-1:0] periph_out,
    input wire logic [psr_pkg::N_SRC-1:0] periph_oe,
    // pin
    output logic pin_out_reg,
    output logic pin_oe_reg
);
    logic use_latch;
    logic src_valid;
    logic [psr_pkg::SRC_IDX_W-1:0] src_idx;
    logic out_next;
    logic oe_next;

    assign use_latch = (src_code == psr_pkg::CODE_LATCH);
    assign src_valid = (src_code < 6'(psr_pkg::N_SRC));
    assign src_idx = src_code[psr_pkg::SRC_IDX_W-1:0];
    // unknown codes leave the pin quiet but keep the port direction
    assign out_next = use_latch ? latch_bit : (src_valid ? periph_out[src_idx] : 1'b0); // RULE11
    assign oe_next = (use_latch || !src_valid) ? !dir_input : periph_oe[src_idx]; // RULE7

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end else begin
            pin_out_reg <= out_next;
            pin_oe_reg <= oe_next;
        end
    end
endmodule : psr_pin_drive

// >>> bench/psr_router_tb.sv
`timescale 1ns/100ps
module psr_router_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic soft_rst = 1'b0;
    logic one_time_lock_option = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [psr_pkg::N_PINS-1:0] pin_in = 16'h0000;
    logic [psr_pkg::N_PINS-1:0] pin_out;
    logic [psr_pkg::N_PINS-1:0] pin_oe;
    logic [psr_pkg::N_PINS-1:0] latch_bits = 16'h0000;
    logic [psr_pkg::N_PINS-1:0] dir_bits = 16'hFFFF;
    logic [psr_pkg::N_SRC-1:0] periph_out = 16'h0000;
    logic [psr_pkg::N_SRC-1:0] periph_oe = 16'h0000;
    logic [psr_pkg::N_INPUTS-1:0] periph_in;
    logic [31:0] rdat;
    int mismatches = 0;
    int checked = 0;

    psr_router u_dut (
        .mclk(mclk), .rst(rst), .soft_rst(soft_rst), .one_time_lock_option(one_time_lock_option),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .port_output_latch_bit(latch_bits), .pin_direction_control(dir_bits),
        .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in)
    );

    always #12.5 mclk = ~mclk;

    task automatic end_sim;
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [7:0] in_adr(input int i);
        return psr_pkg::OFF_IN_BASE + 8'(4 * i);
    endfunction : in_adr

    function automatic logic [7:0] out_adr(input int p);
        return psr_pkg::OFF_OUT_BASE + 8'(4 * p);
    endfunction : out_adr

    // request held until ack is sampled high, then released for a cycle
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= wdat;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            $display("BAD %0t no bus answer", $time);
        end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        xfer(1'b1, adr, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        xfer(1'b0, adr, 32'h0000_0000);
        chk(rdat, exp);
    endtask : rd_chk

    task automatic set_lock(input logic [31:0] d);
        wr(psr_pkg::OFF_LOCK, {24'h00_0000, psr_pkg::KEY_FIRST});
        wr(psr_pkg::OFF_LOCK, {24'h00_0000, psr_pkg::KEY_SECOND});
        wr(psr_pkg::OFF_LOCK, d);
    endtask : set_lock

    task automatic settle;
        repeat (4) @(posedge mclk);
    endtask : settle

    task automatic soft_pulse;
        @(posedge mclk);
        soft_rst <= 1'b1;
        @(posedge mclk);
        soft_rst <= 1'b0;
    endtask : soft_pulse

    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd_chk(psr_pkg::OFF_LOCK, 32'h0000_0000);
        for (int i = 0; i < psr_pkg::N_INPUTS; i++)
            rd_chk(in_adr(i), 32'(psr_pkg::IN_RESET[i]));
        rd_chk(out_adr(3), 32'h0000_0000);
        wr(in_adr(1), 32'hFFFF_FFC5);
        rd_chk(in_adr(1), 32'h0000_0005);
        wr(out_adr(3), 32'h0000_00C5);
        rd_chk(out_adr(3), 32'h0000_0005);
        rd_chk(8'hFC, 32'h0000_0000);
        // pin 3 is an input by direction, so only the peripheral can turn it around
        wr(out_adr(0), 32'h0000_0005);
        periph_out <= 16'h0020;
        periph_oe <= 16'h0020;
        settle();
        chk(32'(pin_out[3]), 32'h0000_0001);
        chk(32'(pin_oe[3]), 32'h0000_0001);
        chk(32'(pin_oe[0]), 32'h0000_0001);
        wr(out_adr(3), 32'h0000_0000);
        latch_bits <= 16'h0008;
        settle();
        chk(32'(pin_out[3]), 32'h0000_0001);
        chk(32'(pin_oe[3]), 32'h0000_0000);
        for (int i = 0; i < psr_pkg::N_INPUTS; i++)
            wr(in_adr(i), 32'(8 + i));
        pin_in <= 16'h0500;
        settle();
        chk(32'(periph_in), 32'h0000_0005);
        wr(psr_pkg::OFF_LOCK, 32'h0000_0001);
        rd_chk(psr_pkg::OFF_LOCK, 32'h0000_0000);
        set_lock(32'h0000_0001);
        rd_chk(psr_pkg::OFF_LOCK, 32'h0000_0001);
        wr(in_adr(0), 32'h0000_000F);
        rd_chk(in_adr(0), 32'h0000_0008);
        wr(out_adr(3), 32'h0000_0005);
        rd_chk(out_adr(3), 32'h0000_0000);
        soft_pulse();
        rd_chk(psr_pkg::OFF_LOCK, 32'h0000_0000);
        rd_chk(in_adr(0), 32'h0000_0008);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        one_time_lock_option <= 1'b1;
        rd_chk(in_adr(0), 32'(psr_pkg::IN_RESET[0]));
        rd_chk(in_adr(2), 32'(psr_pkg::IN_RESET[2]));
        set_lock(32'h0000_0001);
        set_lock(32'h0000_0000);
        rd_chk(psr_pkg::OFF_LOCK, 32'h0000_0001);
        end_sim();
    end

    // whole sequence needs well under a thousand cycles
    initial begin
        #50000;
        mismatches++;
        end_sim();
    end
endmodule : psr_router_tb
